// ### logic/rlcp_pkg.sv
// package: constants, struct layouts and states for the library call block
package rlcp_pkg;

    // ---------------------------------------------------------------
    // stream configuration
    // ---------------------------------------------------------------
    localparam int unsigned STREAM_W        = 32;  // stream data width
    localparam int unsigned FIFO_DEPTH      = 8;   // words in output fifo
    localparam int unsigned FIFO_AW         = 3;   // fifo address width
    localparam bit          STREAM_VALID_OPTION        = 1'b1;
    localparam bit          STREAM_BACKPRESSURE_OPTION = 1'b1;
    localparam bit          STREAM_EMPTY_OPTION        = 1'b1;
    localparam bit          STREAM_PACKET_OPTION       = 1'b1;
    localparam int unsigned BACKPRESSURE_DELAY_CYCLES  = 0;

    // ---------------------------------------------------------------
    // argument layouts
    // ---------------------------------------------------------------
    localparam int unsigned ARR_N   = 4;   // wrapped array elements
    localparam int unsigned BYTE_W  = 8;   // member alignment unit
    localparam int unsigned ARG_W   = 64;  // packed argument width
    localparam int unsigned UARG_W  = 64;  // unpacked argument width
    localparam int unsigned RET_W   = 32;  // return value width

    // packed argument: first software member (scale, 8 bit) at bit 0,
    // then offset (16 bit) directly above, then pad-free tag (8 bit),
    // then array of four bytes; hardware order is reversed
    typedef struct packed {
        logic [ARR_N-1:0][BYTE_W-1:0] arr;    // last member, top bits
        logic [7:0]                   tag;
        logic [15:0]                  offs;
        logic [7:0]                   scale;  // first member, low bits
    } rlcp_arg_s;

    // unpacked C layout: char scale, pad byte, short offs, int bias
    typedef struct packed {
        logic [31:0] bias;    // aligned on 4 bytes
        logic [15:0] offs;    // aligned on 2 bytes
        logic [7:0]  pad0;    // padding ahead of offs
        logic [7:0]  scale;
    } rlcp_uarg_s;

    // packed return value: sum (16 bit) then packet tag (8) then flags
    typedef struct packed {
        logic [7:0]  flags;
        logic [7:0]  tag;
        logic [15:0] sum;
    } rlcp_ret_s;

    // ---------------------------------------------------------------
    // control states
    // ---------------------------------------------------------------
    typedef enum logic [1:0] {
        RLCP_IDLE = 2'h0,
        RLCP_CALC = 2'h1,
        RLCP_HOLD = 2'h3
    } rlcp_state_e;

    localparam logic [7:0] FLAG_SOP = 8'h01;  // flags bit for first beat
    localparam logic [7:0] FLAG_EOP = 8'h02;  // flags bit for last beat
    localparam logic [7:0] FLAG_EMP = 8'h04;  // flags bit for empty beat

endpackage

// ### logic/rlcp_fifo.sv
// small synchronous fifo with registered read data
`timescale 1ns/1ps
`default_nettype none
module rlcp_fifo #(
    parameter int unsigned WIDTH = 32,
    parameter int unsigned DEPTH = 8,
    parameter int unsigned AW    = 3
) (
    // clock and reset
    input  wire logic             clock,
    input  wire logic             rst_n,
    // fill side
    input  wire logic             in_valid,
    output logic                  in_ready,
    input  wire logic [WIDTH-1:0] in_data,
    // drain side
    output logic                  out_valid,
    input  wire logic             out_ready,
    output logic      [WIDTH-1:0] out_data
);
    // ---------------------------------------------------------------
    // storage and pointers
    // ---------------------------------------------------------------
    logic [WIDTH-1:0] mem_r [DEPTH];   // word storage
    logic [AW-1:0]    wp_r;            // write pointer
    logic [AW-1:0]    rp_r;            // read pointer
    logic [AW:0]      cnt_r;           // words held in memory
    logic             oval_r;          // output register holds a word
    logic             wr;
    logic             rd;

    // memory never holds more than depth, so full is honest
    assign in_ready = (cnt_r != AW'(0) + (AW+1)'(DEPTH));
    assign wr       = in_valid && in_ready;
    // refill output register when it is empty or being drained
    assign rd       = (cnt_r != '0) && (!oval_r || out_ready);
    assign out_valid = oval_r;

    // write port
    always_ff @(posedge clock) begin
        if (wr) begin
            mem_r[wp_r] <= in_data;
        end
    end

    // pointers and count
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            wp_r  <= '0;
            rp_r  <= '0;
            cnt_r <= '0;
        end else begin
            if (wr) begin
                wp_r <= AW'(wp_r + AW'(1));
            end
            if (rd) begin
                rp_r <= AW'(rp_r + AW'(1));
            end
            cnt_r <= (AW+1)'(cnt_r + (AW+1)'(wr) - (AW+1)'(rd));
        end
    end

    // registered read data
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            oval_r   <= 1'b0;
            out_data <= '0;
        end else if (rd) begin
            oval_r   <= 1'b1;
            out_data <= mem_r[rp_r];
        end else if (out_ready) begin
            oval_r   <= 1'b0;
        end
    end
endmodule
`default_nettype wire

// ### logic/rlcp_core.sv
// library call module: argument decode, stream input, fifo stream output
`timescale 1ns/1ps
`default_nettype none
module rlcp_core
    import rlcp_pkg::*;
(
    // clock and reset
    input  wire logic                          clock,
    input  wire logic                          srst,
    // call handshake
    input  wire logic                          ivalid,
    output logic                               oready,
    output logic                               ovalid,
    input  wire logic                          iready,
    // call arguments and return value
    input  wire logic [rlcp_pkg::ARG_W-1:0]    arg_packed,
    input  wire logic [rlcp_pkg::UARG_W-1:0]   arg_unpacked,
    output logic      [rlcp_pkg::RET_W-1:0]    ret_value,
    // inbound stream
    input  wire logic [rlcp_pkg::STREAM_W-1:0] src_data,
    input  wire logic                          src_valid,
    output logic                               src_ready,
    input  wire logic                          src_empty,
    input  wire logic                          src_startofpacket,
    input  wire logic                          src_endofpacket,
    // outbound stream
    output logic      [rlcp_pkg::STREAM_W-1:0] dst_data,
    output logic                               dst_valid,
    input  wire logic                          dst_ready,
    output logic                               dst_empty,
    output logic                               dst_startofpacket,
    output logic                               dst_endofpacket,
    // status
    output logic      [15:0]                   beat_count
);
    // ---------------------------------------------------------------
    // helpers
    // ---------------------------------------------------------------
    // sums the four wrapped array bytes; used by the call path only
    function automatic logic [15:0] arr_sum(
        input logic [ARR_N-1:0][BYTE_W-1:0] a
    );
        logic [15:0] s;
        s = '0;
        for (int i = 0; i < int'(ARR_N); i++) begin
            s = 16'(s + 16'(a[i]));
        end
        return s;
    endfunction

    // beat transfer test
    function automatic logic beat(input logic v, input logic r);
        return v && r;
    endfunction

    // ---------------------------------------------------------------
    // reset: block uses active-low internally
    // ---------------------------------------------------------------
    logic rst_n;
    assign rst_n = !srst;

    // ---------------------------------------------------------------
    // argument decode
    // ---------------------------------------------------------------
    rlcp_arg_s  arg_s;      // packed view, member order reversed
    rlcp_uarg_s uarg_s;     // padded view
    assign arg_s  = rlcp_arg_s'(arg_packed);
    assign uarg_s = rlcp_uarg_s'(arg_unpacked);

    // ---------------------------------------------------------------
    // call pipeline: one result register, held until taken
    // ---------------------------------------------------------------
    rlcp_state_e state_r;     // call state
    rlcp_ret_s   ret_r;       // result register
    logic        take_call;
    logic        give_ret;

    // a new call may enter in idle, or in hold while the parked result is taken
    assign oready    = (state_r == RLCP_IDLE)
                    || (state_r == RLCP_HOLD && iready);
    // one valid strobe qualifies all argument inputs together
    assign take_call = beat(ivalid, oready);
    assign give_ret  = beat(ovalid, iready);
    assign ovalid    = (state_r == RLCP_HOLD);
    assign ret_value = ret_r;

    // call state machine
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            state_r <= RLCP_IDLE;
        end else begin
            case (state_r)
                RLCP_IDLE: begin
                    if (take_call) begin
                        state_r <= RLCP_CALC;
                    end
                end
                RLCP_CALC: begin
                    state_r <= RLCP_HOLD;
                end
                RLCP_HOLD: begin
                    if (take_call) begin
                        state_r <= RLCP_CALC;
                    end else if (give_ret) begin
                        state_r <= RLCP_IDLE;
                    end
                end
                default: begin
                    state_r <= RLCP_IDLE;
                end
            endcase
        end
    end

    // captured arguments; the adder sits on the input, the calc stage only copies acc_r and tag_r
    logic [15:0] acc_r;
    logic [7:0]  tag_r;
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            acc_r <= '0;
            tag_r <= '0;
        end else if (take_call) begin
            acc_r <= 16'(arr_sum(arg_s.arr) + arg_s.offs
                         + 16'(arg_s.scale) + 16'(uarg_s.scale)
                         + uarg_s.offs + uarg_s.bias[15:0]);
            tag_r <= arg_s.tag;
        end
    end

    // result register written in calc stage; lowest member in low bits
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            ret_r <= '0;
        end else if (state_r == RLCP_CALC) begin
            ret_r.sum   <= acc_r;
            ret_r.tag   <= tag_r;
            ret_r.flags <= '0;
        end
    end

    // ---------------------------------------------------------------
    // inbound stream: caller logic shares our clock, no sync stages
    // backpressure delay of zero means ready and transfer line up
    // ---------------------------------------------------------------
    logic        fifo_in_ready;  // fifo has room
    logic        src_take;
    logic [STREAM_W+2:0] fifo_in_word; // data plus sideband bits
    logic [STREAM_W+2:0] fifo_out_word;
    logic        fifo_out_valid;

    assign src_ready = STREAM_BACKPRESSURE_OPTION ? fifo_in_ready
                                                  : 1'b1;
    assign src_take  = beat(STREAM_VALID_OPTION ? src_valid : 1'b1,
                            src_ready);

    // sideband bits ride in the word beside the data
    assign fifo_in_word = {
        STREAM_PACKET_OPTION ? src_endofpacket   : 1'b0,
        STREAM_PACKET_OPTION ? src_startofpacket : 1'b0,
        STREAM_EMPTY_OPTION  ? src_empty         : 1'b0,
        src_data
    };

    // ---------------------------------------------------------------
    // outbound fifo; back-pressure from dst_ready reaches src_ready
    // ---------------------------------------------------------------
    rlcp_fifo #(
        .WIDTH (STREAM_W + 3),
        .DEPTH (FIFO_DEPTH),
        .AW    (FIFO_AW)
    ) u_fifo (
        .clock     (clock),
        .rst_n     (rst_n),
        .in_valid  (src_take),
        .in_ready  (fifo_in_ready),
        .in_data   (fifo_in_word),
        .out_valid (fifo_out_valid),
        .out_ready (dst_ready),
        .out_data  (fifo_out_word)
    );

    // outbound ports, from fifo output register
    assign dst_valid         = STREAM_VALID_OPTION ? fifo_out_valid
                                                   : 1'b1;
    assign dst_data          = fifo_out_word[STREAM_W-1:0];
    assign dst_empty         = fifo_out_word[STREAM_W];
    assign dst_startofpacket = fifo_out_word[STREAM_W+1];
    assign dst_endofpacket   = fifo_out_word[STREAM_W+2];

    // ---------------------------------------------------------------
    // per-instance beat counter; it keeps counting across calls until reset
    // ---------------------------------------------------------------
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            beat_count <= '0;
        end else if (beat(fifo_out_valid, dst_ready)) begin
            beat_count <= 16'(beat_count + 16'h0001);
        end
    end
endmodule
`default_nettype wire

// ### dv/rlcp_core_props.sv
// port checker for the library call block, bound to rlcp_core
`timescale 1ns/1ps
`default_nettype none
module rlcp_core_props
    import rlcp_pkg::*;
(
    // clock and reset
    input wire logic                       clock,
    input wire logic                       srst,
    // call side
    input wire logic                       ivalid,
    input wire logic                       oready,
    input wire logic                       ovalid,
    input wire logic                       iready,
    input wire logic [rlcp_pkg::ARG_W-1:0] arg_packed,
    input wire logic [rlcp_pkg::RET_W-1:0] ret_value,
    // stream side
    input wire logic                       src_valid,
    input wire logic                       src_ready,
    input wire logic [rlcp_pkg::STREAM_W-1:0] dst_data,
    input wire logic                       dst_valid,
    input wire logic                       dst_ready,
    input wire logic [15:0]                beat_count
);
    default clocking cb @(posedge clock); endclocking
    default disable iff (srst);
    // ---------------------------------------------------------------
    // steps of a call and of a beat
    // ---------------------------------------------------------------
    sequence call_taken; ivalid && oready; endsequence
    sequence res_stalled; ovalid && !iready; endsequence
    // only when the output register is empty is the latency bounded, at one or two cycles
    sequence beat_in; src_valid && src_ready && !dst_valid; endsequence
    // ---------------------------------------------------------------
    // checks
    // ---------------------------------------------------------------
    rst_clean_a: assert property ($past(srst) |-> oready && src_ready
        && !ovalid && !dst_valid && beat_count == 16'h0000)
        else $error("outputs not cleared by reset");
    call_lat_a: assert property (call_taken |-> ##2 ovalid)
        else $error("result late or missing");
    ret_tag_a: assert property (call_taken |-> ##2
        ret_value[23:16] == $past(arg_packed[31:24], 2))
        else $error("tag member taken from wrong slice");
    ret_hold_a: assert property (res_stalled |=> ovalid
        && $stable(ret_value)) else $error("result dropped");
    call_refuse_a: assert property (res_stalled |-> !oready)
        else $error("call taken while result held");
    dst_hold_a: assert property (dst_valid && !dst_ready |=>
        dst_valid && $stable(dst_data)) else $error("beat dropped");
    beat_cnt_a: assert property (dst_valid && dst_ready |=>
        beat_count == $past(beat_count) + 16'h0001)
        else $error("beat count not advanced");
    dst_lat_a: assert property (beat_in |-> ##[1:2] dst_valid)
        else $error("beat not forwarded");
endmodule
bind rlcp_core rlcp_core_props u_props (.clock(clock), .srst(srst),
    .ivalid(ivalid), .oready(oready), .ovalid(ovalid), .iready(iready),
    .arg_packed(arg_packed), .ret_value(ret_value),
    .src_valid(src_valid), .src_ready(src_ready), .dst_data(dst_data),
    .dst_valid(dst_valid), .dst_ready(dst_ready),
    .beat_count(beat_count));
`default_nettype wire

// ### dv/rlcp_caller_model.sv
// far-side model: caller pipeline taking results and outbound beats
`timescale 1ns/1ps
`default_nettype none
module rlcp_caller_model (
    // clock and reset
    input  wire logic       clock,
    input  wire logic       srst,
    // stall mode: 0 prompt, 1 random, 2 hold off
    input  wire logic [1:0] mode,
    // readiness toward the block
    output logic            iready,
    output logic            dst_ready
);
    // ---------------------------------------------------------------
    // readiness, changed only just after an edge
    // ---------------------------------------------------------------
    // zero backpressure delay: a low ready stops the next transfer
    always_ff @(posedge clock) begin
        if (srst || mode == 2'h2) begin // held off: buffer must fill
            iready    <= 1'b0;
            dst_ready <= 1'b0;
        end else if (mode == 2'h1) begin // coin flip each cycle
            iready    <= 1'($urandom);
            dst_ready <= 1'($urandom);
        end else begin // prompt taker
            iready    <= 1'b1;
            dst_ready <= 1'b1;
        end
    end
endmodule
`default_nettype wire

// ### dv/rlcp_core_tb.sv
// self-checking bench: calls, packets, buffer fill, far-side stalls
`timescale 1ns/1ps
`default_nettype none
module rlcp_core_tb;
    import rlcp_pkg::*;
    // ---------------------------------------------------------------
    // signals and scoreboard
    // ---------------------------------------------------------------
    logic        clock = 1'b0;
    logic        srst = 1'b1;
    logic        ivalid = 1'b0, oready, ovalid, iready;
    logic [63:0] arg_packed = '0, arg_unpacked = '0;
    logic [31:0] ret_value, src_data = '0, dst_data;
    logic        src_valid = 1'b0, src_ready, src_empty = 1'b0;
    logic        src_startofpacket = 1'b0, src_endofpacket = 1'b0;
    logic        dst_valid, dst_ready, dst_empty;
    logic        dst_startofpacket, dst_endofpacket;
    logic [15:0] beat_count;
    logic [1:0]  mode = 2'h0;        // far-side stall mode
    logic [31:0] q_ret[$];           // expected results, oldest first
    logic [34:0] q_beat[$];          // expected beats with sidebands
    int          n_errors = 0, n_compared = 0, cycles = 0;
    int          n_sent = 0;         // beats offered on the inbound side

    always #2.5 clock = ~clock;      // 200 MHz

    rlcp_core DUT (.clock(clock), .srst(srst), .ivalid(ivalid),
        .oready(oready), .ovalid(ovalid), .iready(iready),
        .arg_packed(arg_packed), .arg_unpacked(arg_unpacked),
        .ret_value(ret_value), .src_data(src_data),
        .src_valid(src_valid), .src_ready(src_ready),
        .src_empty(src_empty), .src_startofpacket(src_startofpacket),
        .src_endofpacket(src_endofpacket), .dst_data(dst_data),
        .dst_valid(dst_valid), .dst_ready(dst_ready),
        .dst_empty(dst_empty), .dst_startofpacket(dst_startofpacket),
        .dst_endofpacket(dst_endofpacket), .beat_count(beat_count));
    rlcp_caller_model u_far (.clock(clock), .srst(srst), .mode(mode),
        .iready(iready), .dst_ready(dst_ready));
    // ---------------------------------------------------------------
    // reporting and comparison
    // ---------------------------------------------------------------
    task automatic fail(input string m);
        n_errors++;
        $display("wrong value at %0t: %s", $time, m);
    endtask
    task automatic cmp_ret(input logic [31:0] g, input logic [31:0] e);
        n_compared++;
        if (g !== e) fail("return value");
    endtask
    task automatic cmp_beat(input logic [34:0] g, input logic [34:0] e);
        n_compared++;
        if (g !== e) fail("outbound beat");
    endtask
    task automatic cmp_cnt(input logic [15:0] g, input logic [15:0] e);
        n_compared++;
        if (g !== e) fail("beat count");
    endtask
    task automatic cmp_bit(input logic g, input logic e);
        n_compared++;
        if (g !== e) fail("inbound ready");
    endtask
    task automatic tally_and_finish();
        if (n_errors == 0 && n_compared > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask
    // ---------------------------------------------------------------
    // drivers: each notes its expectation before the request
    // ---------------------------------------------------------------
    // args by value; pad byte random to prove it is ignored
    task automatic do_call();
        logic [63:0] a, u;
        logic [15:0] s;
        a = {$urandom, $urandom};
        u = {$urandom, $urandom};
        s = a[7:0] + a[23:8] + a[39:32] + a[47:40] + a[55:48]
            + a[63:56] + u[7:0] + u[31:16] + u[47:32];
        q_ret.push_back({8'h00, a[31:24], s});
        arg_packed <= a;
        arg_unpacked <= u;
        ivalid <= 1'b1;
        do @(posedge clock); while (oready !== 1'b1);
    endtask
    // n beats, first marked start, last marked end, random empty on the last beat
    task automatic send_pkt(input int n);
        logic [31:0] d;
        for (int i = 0; i < n; i++) begin
            d = $urandom;
            q_beat.push_back({d[0] & (i == n-1), i == n-1, i == 0, d});
            n_sent++;
            src_data <= d;
            src_empty <= d[0] & (i == n-1);
            src_startofpacket <= (i == 0);
            src_endofpacket <= (i == n-1);
            src_valid <= 1'b1;
            do @(posedge clock); while (src_ready !== 1'b1);
        end
    endtask
    // calls and packets at once: the two paths must not interfere
    task automatic traffic();
        fork
            begin repeat (12) do_call(); ivalid <= 1'b0; end
            begin
                send_pkt(4);
                send_pkt(1);
                send_pkt(6);
                src_valid <= 1'b0;
            end
        join
    endtask
    task automatic drain();
        for (int i = 0; i < 400 && q_ret.size() + q_beat.size() > 0; i++)
            @(posedge clock);
        if (q_ret.size() + q_beat.size() > 0) fail("outputs missing");
    endtask
    // ---------------------------------------------------------------
    // monitor: take oldest note whenever a result or a beat is handed over
    // ---------------------------------------------------------------
    always @(posedge clock) begin
        if (!srst && ovalid === 1'b1 && iready === 1'b1) begin
            if (q_ret.size() == 0) fail("unexpected result");
            else cmp_ret(ret_value, q_ret.pop_front());
        end
        if (!srst && dst_valid === 1'b1 && dst_ready === 1'b1) begin
            if (q_beat.size() == 0) fail("unexpected beat");
            else cmp_beat({dst_empty, dst_endofpacket, dst_startofpacket,
                dst_data}, q_beat.pop_front());
        end
    end
    // hang guard, well above the few hundred cycles needed
    always @(posedge clock) begin
        cycles++;
        if (cycles == 20000) begin
            fail("timeout");
            tally_and_finish();
        end
    end
    // ---------------------------------------------------------------
    // main sequence
    // ---------------------------------------------------------------
    initial begin
        void'($urandom(32'h0a1c3ef8));
        repeat (8) @(posedge clock);
        srst <= 1'b0;
        @(posedge clock);
        for (int m = 0; m < 2; m++) begin // prompt, then stalling far side
            mode <= m[1:0];
            traffic();
            drain();
        end
        mode <= 2'h2; // far side holds off: 8 stored plus 1 in output
        repeat (2) @(posedge clock);
        send_pkt(9);
        src_valid <= 1'b0;
        @(negedge clock);
        cmp_bit(src_ready, 1'b0);
        @(posedge clock);
        mode <= 2'h0;
        drain();
        // counter settles one edge after the last handover
        @(negedge clock);
        cmp_cnt(beat_count, 16'(n_sent));
        tally_and_finish();
    end
endmodule
`default_nettype wire
